// ==== hdl/gpioc_top.sv ====
// general-purpose pin controller with overlaid functions, APB slave
//
// The APB slave port and the placing of the registers are this design's own decisions.
module gpioc_top
    import gpioc_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           sw_rst,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic [21:0]    gpio_pin_in,
    output gpioc_pins_type      gpio_pins,
    input  wire logic           serial_pin_clock,
    input  wire logic           serial_pin_data_out,
    input  wire logic           serial_pin_load,
    output logic                serial_pin_data_in,
    input  wire logic           mgmt1_clock,
    input  wire logic           mgmt1_data_out,
    input  wire logic           mgmt1_data_oe,
    output logic                mgmt1_data_in,
    input  wire logic           slave_mgmt_data_out,
    input  wire logic           slave_mgmt_data_oe,
    output logic                slave_mgmt_clock,
    output logic                slave_mgmt_data_in,
    output logic                mgmt_slave_mode,
    output logic      [3:0]     cpu_strap_pins,
    input  wire logic [31:0]    serial_sd_in,
    output logic      [31:0]    front_sd_out,
    output logic                irq
);
    logic [21:0]    drive_reg;
    logic [21:0]    dir_reg;
    logic [21:0]    alt0_reg;
    logic [21:0]    alt1_reg;
    logic [21:0]    flags_reg;
    logic [21:0]    mask_reg;
    logic [21:0]    lvl_reg;
    logic [21:0]    s1_reg;
    logic [21:0]    s2_reg;
    logic [21:0]    s3_reg;
    logic [4:0]     map_reg [GPIOC_NDET];
    logic [3:0]     strap_reg;
    logic           slave_reg;
    logic           prime_reg;
    logic           pready_reg;
    logic           pslverr_reg;
    logic           irq_reg;
    logic [31:0]    prdata_reg;
    logic [31:0]    sd_reg;
    gpioc_pins_type pins_reg;
    gpioc_pins_type pins_next;
    logic [31:0]    sd_next;
    logic [21:0]    lvl_next;
    logic [21:0]    chg;
    logic [21:0]    clr;
    logic [31:0]    rd_data;
    logic           rd_hit;
    logic           wr_en;
    logic           rd_take;

    assign wr_en   = psel && penable && pready_reg && pwrite;
    assign rd_take = psel && penable && !pready_reg;

    // one wait state: data and error settle while pready is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end
        else
        begin
            pready_reg  <= rd_take;
            pslverr_reg <= rd_take && !rd_hit;
            prdata_reg  <= (rd_take && !pwrite) ? rd_data : 32'h00000000;
        end
    end

    always_comb
    begin
        rd_data = 32'h00000000;
        rd_hit  = 1'b1;
        case (paddr)
            GPIOC_OFF_DRIVE: rd_data = {10'h000, drive_reg};
            GPIOC_OFF_SET:   rd_data = 32'h00000000;
            GPIOC_OFF_CLR:   rd_data = 32'h00000000;
            GPIOC_OFF_LEVEL: rd_data = {10'h000, lvl_reg};
            GPIOC_OFF_DIR:   rd_data = {10'h000, dir_reg};
            GPIOC_OFF_ALT0:  rd_data = {10'h000, alt0_reg};
            GPIOC_OFF_ALT1:  rd_data = {10'h000, alt1_reg};
            GPIOC_OFF_FLAGS: rd_data = {10'h000, flags_reg};
            GPIOC_OFF_MASK:  rd_data = {10'h000, mask_reg};
            GPIOC_OFF_IDENT: rd_data = {10'h000, flags_reg & mask_reg};
            default:
            begin
                rd_hit = 1'b0;
                for (int k = 0; k < GPIOC_NDET; k++)
                begin
                    if (paddr == GPIOC_OFF_MAP0 + 8'(4 * k))
                    begin
                        rd_hit  = 1'b1;
                        rd_data = {27'h0000000, map_reg[k]};
                    end
                end
            end
        endcase
    end

    // drive value with atomic set and clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drive_reg <= GPIOC_RST_PINS;
        else if (sw_rst)
            drive_reg <= GPIOC_RST_PINS;
        else if (wr_en && paddr == GPIOC_OFF_DRIVE)
            drive_reg <= pwdata[21:0];
        else if (wr_en && paddr == GPIOC_OFF_SET)
            drive_reg <= drive_reg | pwdata[21:0];
        else if (wr_en && paddr == GPIOC_OFF_CLR)
            drive_reg <= drive_reg & ~pwdata[21:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_reg  <= GPIOC_RST_PINS;
            mask_reg <= GPIOC_RST_PINS;
            for (int k = 0; k < GPIOC_NDET; k++)
                map_reg[k] <= GPIOC_RST_MAP;
        end
        else if (sw_rst)
        begin
            dir_reg  <= GPIOC_RST_PINS;
            mask_reg <= GPIOC_RST_PINS;
            for (int k = 0; k < GPIOC_NDET; k++)
                map_reg[k] <= GPIOC_RST_MAP;
        end
        else if (wr_en)
        begin
            if (paddr == GPIOC_OFF_DIR)
                dir_reg <= pwdata[21:0];
            if (paddr == GPIOC_OFF_MASK)
                mask_reg <= pwdata[21:0];
            for (int k = 0; k < GPIOC_NDET; k++)
                if (paddr == GPIOC_OFF_MAP0 + 8'(4 * k))
                    map_reg[k] <= pwdata[4:0];
        end
    end

    // soft reset deliberately ignored so pin muxing survives it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alt0_reg <= GPIOC_RST_PINS;
            alt1_reg <= GPIOC_RST_PINS;
        end
        else if (wr_en && paddr == GPIOC_OFF_ALT0)
            alt0_reg <= pwdata[21:0];
        else if (wr_en && paddr == GPIOC_OFF_ALT1)
            alt1_reg <= pwdata[21:0];
    end

    // three-stage input sampler; clocked through reset so straps see pins
    always_ff @(posedge pclk)
    begin
        s1_reg <= gpio_pin_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    always_ff @(posedge pclk)
    begin
        if (!presetn)
        begin
            strap_reg <= s3_reg[GPIOC_STRAP_LSB +: 4];
            slave_reg <= (s3_reg[GPIOC_STRAP_LSB +: 4] == GPIOC_STRAP_SLAVE);
        end
    end

    // a bit moves only once the second and third stages agree
    assign lvl_next = (lvl_reg & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
    assign chg      = prime_reg ? (lvl_next ^ lvl_reg) : GPIOC_RST_PINS;
    assign clr      = (wr_en && paddr == GPIOC_OFF_FLAGS) ? pwdata[21:0] : GPIOC_RST_PINS;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lvl_reg   <= GPIOC_RST_PINS;
            prime_reg <= 1'b0;
        end
        else
        begin
            // first cycle loads the level without raising flags
            lvl_reg   <= prime_reg ? lvl_next : s3_reg;
            prime_reg <= 1'b1;
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_reg <= GPIOC_RST_PINS;
        else if (sw_rst)
            flags_reg <= chg;
        else
            flags_reg <= (flags_reg & ~clr) | chg;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(flags_reg & mask_reg);
    end

    always_comb
    begin
        pins_next.out = drive_reg;
        pins_next.oe  = dir_reg;
        for (int i = 0; i < GPIOC_NPIN; i++)
        begin
            case (gpioc_alt_type'({alt1_reg[i], alt0_reg[i]}))
                GPIOC_NORMAL: ;
                GPIOC_FUNC1:
                begin
                    pins_next.oe[i] = 1'b0; // functions held outside release the pin
                    if (i == GPIOC_SER_CLK_PIN)
                    begin
                        pins_next.out[i] = serial_pin_clock;
                        pins_next.oe[i]  = 1'b1;
                    end
                    if (i == GPIOC_SER_DO_PIN)
                    begin
                        pins_next.out[i] = serial_pin_data_out;
                        pins_next.oe[i]  = 1'b1;
                    end
                    if (i == GPIOC_SER_LD_PIN)
                    begin
                        pins_next.out[i] = serial_pin_load;
                        pins_next.oe[i]  = 1'b1;
                    end
                    if (i == GPIOC_MDC_PIN)
                    begin
                        pins_next.out[i] = mgmt1_clock;
                        pins_next.oe[i]  = 1'b1;
                    end
                    if (i == GPIOC_MDIO_PIN)
                    begin
                        pins_next.out[i] = mgmt1_data_out;
                        pins_next.oe[i]  = mgmt1_data_oe;
                    end
                end
                GPIOC_FUNC2: pins_next.oe[i] = 1'b0;
                GPIOC_FUNC3:
                    if (i >= GPIOC_DET_PIN0 && i < GPIOC_DET_PIN0 + GPIOC_NDET)
                        pins_next.oe[i] = 1'b0;
                default: ;
            endcase
        end
        if (slave_reg)
        begin
            pins_next.oe[GPIOC_MDC_PIN]   = 1'b0;
            pins_next.out[GPIOC_MDIO_PIN] = slave_mgmt_data_out;
            pins_next.oe[GPIOC_MDIO_PIN]  = slave_mgmt_data_oe;
        end
    end

    always_comb
    begin
        sd_next = serial_sd_in;
        for (int k = 0; k < GPIOC_NDET; k++)
            if ({alt1_reg[GPIOC_DET_PIN0 + k], alt0_reg[GPIOC_DET_PIN0 + k]} == GPIOC_FUNC3)
                sd_next[map_reg[k]] = lvl_reg[GPIOC_DET_PIN0 + k];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins_reg <= '0;
            sd_reg   <= 32'h00000000;
        end
        else
        begin
            pins_reg <= pins_next;
            sd_reg   <= sd_next;
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign gpio_pins          = pins_reg;
    assign irq                = irq_reg;
    assign front_sd_out       = sd_reg;
    assign serial_pin_data_in = lvl_reg[GPIOC_SER_DI_PIN];
    assign mgmt1_data_in      = lvl_reg[GPIOC_MDIO_PIN];
    assign slave_mgmt_clock   = lvl_reg[GPIOC_MDC_PIN];
    assign slave_mgmt_data_in = lvl_reg[GPIOC_MDIO_PIN];
    assign mgmt_slave_mode    = slave_reg;
    assign cpu_strap_pins     = strap_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    normal_drive_a: assert property ((alt0_reg | alt1_reg) == 22'h0 && !slave_reg |=>
        pins_reg.oe == $past(dir_reg) && pins_reg.out == $past(drive_reg))
        else $error("normal pin drive mismatch");
    set_mask_a: assert property (wr_en && paddr == GPIOC_OFF_SET && !sw_rst |=>
        drive_reg == ($past(drive_reg) | $past(pwdata[21:0])))
        else $error("set mask wrong");
    clr_mask_a: assert property (wr_en && paddr == GPIOC_OFF_CLR && !sw_rst |=>
        drive_reg == ($past(drive_reg) & ~$past(pwdata[21:0])))
        else $error("clear mask wrong");
    alt_keep_a: assert property (sw_rst && !wr_en |=>
        $stable(alt0_reg) && $stable(alt1_reg))
        else $error("alt select lost on soft reset");
    flag_set_a: assert property (chg != 22'h0 |=>
        (flags_reg & $past(chg)) == $past(chg))
        else $error("change flag not set");
    irq_cause_a: assert property (irq_reg |-> $past(flags_reg & mask_reg) != 22'h0)
        else $error("interrupt without active source");
    ident_read_a: assert property (rd_take && !pwrite && paddr == GPIOC_OFF_IDENT |=>
        pready_reg && prdata_reg[21:0] == $past(flags_reg & mask_reg))
        else $error("active source read wrong");
    slave_take_a: assert property (slave_reg |=> !pins_reg.oe[GPIOC_MDC_PIN] &&
        pins_reg.oe[GPIOC_MDIO_PIN] == $past(slave_mgmt_data_oe))
        else $error("slave pins not taken over");
endmodule

// ==== shared/gpioc_pkg.sv ====
// constants and types shared by the pin controller
package gpioc_pkg;
    localparam int GPIOC_NPIN  = 22;
    localparam int GPIOC_NDET  = 6;
    localparam int GPIOC_NPORT = 32;
    // register byte offsets
    localparam logic [7:0] GPIOC_OFF_DRIVE = 8'h00;
    localparam logic [7:0] GPIOC_OFF_SET   = 8'h04;
    localparam logic [7:0] GPIOC_OFF_CLR   = 8'h08;
    localparam logic [7:0] GPIOC_OFF_LEVEL = 8'h0C;
    localparam logic [7:0] GPIOC_OFF_DIR   = 8'h10;
    localparam logic [7:0] GPIOC_OFF_ALT0  = 8'h14;
    localparam logic [7:0] GPIOC_OFF_ALT1  = 8'h18;
    localparam logic [7:0] GPIOC_OFF_FLAGS = 8'h1C;
    localparam logic [7:0] GPIOC_OFF_MASK  = 8'h20;
    localparam logic [7:0] GPIOC_OFF_IDENT = 8'h24;
    localparam logic [7:0] GPIOC_OFF_MAP0  = 8'h28;
    // reset values and the slave strap code
    localparam logic [21:0] GPIOC_RST_PINS = 22'h000000;
    localparam logic [4:0]  GPIOC_RST_MAP  = 5'h00;
    localparam logic [3:0]  GPIOC_STRAP_SLAVE = 4'hF;
    // pin positions
    localparam int GPIOC_SER_CLK_PIN  = 0;
    localparam int GPIOC_SER_DO_PIN   = 1;
    localparam int GPIOC_SER_DI_PIN   = 2;
    localparam int GPIOC_SER_LD_PIN   = 3;
    localparam int GPIOC_DET_PIN0     = 10;
    localparam int GPIOC_MDC_PIN      = 14;
    localparam int GPIOC_MDIO_PIN     = 15;
    localparam int GPIOC_STRAP_LSB    = 18;
    typedef enum logic [1:0] {
        GPIOC_NORMAL = 2'b00,
        GPIOC_FUNC1  = 2'b01,
        GPIOC_FUNC2  = 2'b10,
        GPIOC_FUNC3  = 2'b11
    } gpioc_alt_type;
    typedef struct packed {
        logic [21:0] out;
        logic [21:0] oe;
    } gpioc_pins_type;
endpackage

// ==== sim/gpio_controller_with_alt_select_test.sv ====
// self-checking bench of the pin controller over its APB port
module gpio_controller_with_alt_select_test
    import gpioc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           pclk;
    logic           presetn;
    logic           sw_rst;
    logic           psel;
    logic           penable;
    logic           pwrite;
    logic [7:0]     paddr;
    logic [31:0]    pwdata;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic [21:0]    pin_level;
    logic [21:0]    ext_val;
    gpioc_pins_type gpio_pins;
    logic           ser_clk;
    logic           mgmt_clk;
    logic           slv_oe;
    logic [3:0]     strap;
    logic           slv_mode;
    logic [31:0]    serial_sd;
    logic [31:0]    front_sd;
    logic           irq;
    logic           sdi;
    logic           mdi1;
    logic           smc;
    logic           smd;
    logic [31:0]    rdv;
    logic           errv;
    int             miscompares;
    int             comparisons;

    gpioc_top u_gpioc_top (.pclk(pclk), .presetn(presetn), .sw_rst(sw_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_pin_in(pin_level),
        .gpio_pins(gpio_pins), .serial_pin_clock(ser_clk), .serial_pin_data_out(1'b0),
        .serial_pin_load(1'b0), .serial_pin_data_in(sdi), .mgmt1_clock(mgmt_clk),
        .mgmt1_data_out(1'b0), .mgmt1_data_oe(1'b0), .mgmt1_data_in(mdi1),
        .slave_mgmt_data_out(1'b1), .slave_mgmt_data_oe(slv_oe), .slave_mgmt_clock(smc),
        .slave_mgmt_data_in(smd), .mgmt_slave_mode(slv_mode), .cpu_strap_pins(strap),
        .serial_sd_in(serial_sd), .front_sd_out(front_sd), .irq(irq));

    gpioc_board_model u_gpioc_board_model (.gpio_pins(gpio_pins), .ext_val(ext_val),
        .pin_level(pin_level));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // holds the request until pready is sampled high; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rdv, exp);
    endtask

    task automatic t_reset_vals();
        rd(GPIOC_OFF_DIR, 32'h00000000);
        rd(GPIOC_OFF_ALT0, 32'h00000000);
        chk(32'(gpio_pins.oe), 32'h00000000);
        chk(32'(strap), 32'h00000000);
        chk(32'(slv_mode), 32'h00000000);
        apb(1'b0, 8'hFC, 32'h00000000);
        chk(32'(errv), 32'h00000001);
        chk(rdv, 32'h00000000);
    endtask

    task automatic t_drive();
        wr(GPIOC_OFF_DIR, 32'h0000000F);
        wr(GPIOC_OFF_DRIVE, 32'h00000005);
        wr(GPIOC_OFF_SET, 32'h0000000A);
        rd(GPIOC_OFF_DRIVE, 32'h0000000F);
        wr(GPIOC_OFF_CLR, 32'h00000003);
        rd(GPIOC_OFF_DRIVE, 32'h0000000C);
        chk(32'(gpio_pins.oe), 32'h0000000F);
        chk(32'(gpio_pins.out & gpio_pins.oe), 32'h0000000C);
        repeat (6) @(posedge pclk);
        rd(GPIOC_OFF_LEVEL, 32'h0000000C);
        chk(32'(sdi), 32'h00000001);
    endtask

    task automatic t_irq();
        wr(GPIOC_OFF_FLAGS, 32'h003FFFFF);
        rd(GPIOC_OFF_FLAGS, 32'h00000000);
        ext_val[5] <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(GPIOC_OFF_FLAGS, 32'h00000020);
        chk(32'(irq), 32'h00000000);
        wr(GPIOC_OFF_MASK, 32'h00000030);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h00000001);
        rd(GPIOC_OFF_IDENT, 32'h00000020);
        wr(GPIOC_OFF_FLAGS, 32'h00000020);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h00000000);
        rd(GPIOC_OFF_IDENT, 32'h00000000);
    endtask

    task automatic t_alt();
        wr(GPIOC_OFF_MAP0, 32'h00000005);
        wr(GPIOC_OFF_ALT1, 32'h00000400);
        wr(GPIOC_OFF_ALT0, 32'h0000C401);
        ser_clk <= 1'b1;
        mgmt_clk <= 1'b1;
        ext_val[10] <= 1'b1;
        ext_val[15] <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(mdi1), 32'h00000001);
        chk(32'(gpio_pins.oe[0] & gpio_pins.out[0]), 32'h00000001);
        chk(32'(gpio_pins.oe[14] & gpio_pins.out[14]), 32'h00000001);
        chk(front_sd, 32'h0000FF20);
        @(posedge pclk);
        sw_rst <= 1'b1;
        @(posedge pclk);
        sw_rst <= 1'b0;
        rd(GPIOC_OFF_ALT0, 32'h0000C401);
        rd(GPIOC_OFF_DIR, 32'h00000000);
        // cleared map now points the enabled detect at port 0
        chk(front_sd, 32'h0000FF01);
    endtask

    task automatic t_slave();
        ext_val[21:18] <= 4'hF;
        ext_val[14] <= 1'b1;
        slv_oe <= 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(strap), 32'h0000000F);
        chk(32'(slv_mode), 32'h00000001);
        chk(32'(gpio_pins.oe[15] & gpio_pins.out[15]), 32'h00000001);
        chk(32'(gpio_pins.oe[14]), 32'h00000000);
        chk(32'({smc, smd}), 32'h00000003);
        rd(GPIOC_OFF_ALT0, 32'h00000000);
    endtask

    initial
    begin
        presetn = 1'b0;
        sw_rst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        ext_val = 22'h000000;
        ser_clk = 1'b0;
        mgmt_clk = 1'b0;
        slv_oe = 1'b0;
        serial_sd = 32'h0000FF00;
        miscompares = 0;
        comparisons = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_vals();
        t_drive();
        t_irq();
        t_alt();
        t_slave();
        report_and_stop();
    end

    // whole run is under two hundred cycles; this only cuts a hang short
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end
endmodule

// ==== sim/gpioc_board_model.sv ====
// board around the pins: drives every pin the controller leaves released
module gpioc_board_model
    import gpioc_pkg::*;
(
    input  wire gpioc_pins_type gpio_pins,
    input  wire logic [21:0]    ext_val,
    output logic      [21:0]    pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // controller drive wins; board only fills released pins, so no contention
    assign pin_level = (gpio_pins.oe & gpio_pins.out) | (~gpio_pins.oe & ext_val);
endmodule
